/* File: rtl/cycle_counter.sv */
// Down counter that holds the clocks left in the current instruction
`timescale 1ns/1ps
module cycle_counter #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic [W-1:0] count,
  output logic last
);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  // Last busy clock of an instruction
  assign last = (count == ONE);

  // Load on issue, otherwise run down to zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= ZERO;
    end else if (load) begin
      count <= loadValue;
    end else if (count != ZERO) begin
      count <= count - ONE;
    end
  end
endmodule // cycle_counter

/* File: rtl/instr_timing_decoder.sv */
// Instruction length and clock-count decoder with execution sequencer
`timescale 1ns/1ps
module instr_timing_decoder (
  input wire logic clk,
  input wire logic nrst,
  input wire logic opValid,
  input wire logic [instr_timing_pkg::OPW-1:0] opcode,
  input wire logic condTaken,
  input wire logic [instr_timing_pkg::WAITW-1:0] codeWait,
  output logic opReady,
  output logic busy,
  output logic execDone,
  output logic pcStep,
  output logic [instr_timing_pkg::LENW-1:0] instrLen,
  output logic [instr_timing_pkg::CYCW-1:0] execCycles,
  output logic unknownOp
);
  import instr_timing_pkg::*;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } seq_e;

  seq_e state;
  seq_e next_state;

  // ----------------------------------------
  // Operand field decode
  // ----------------------------------------
  logic [3:0] row;
  logic [3:0] col;
  logic colRn;
  logic colRi;
  logic colDir;
  logic colImm;
  logic aluRow;
  logic logicRow;

  // Row and column of the opcode map
  assign row = opcode[7:4];
  assign col = opcode[3:0];
  assign colRn = opcode[3];
  assign colRi = (opcode[3:1] == COL_IND);
  assign colDir = (col == COL_DIR);
  assign colImm = (col == COL_IMM);
  assign logicRow = (row == ROW_ORL) || (row == ROW_ANL) || (row == ROW_XRL);
  assign aluRow = logicRow || (row == ROW_ADD) || (row == ROW_ADDC) || (row == ROW_SUBB);

  // ----------------------------------------
  // Length and clock table
  // ----------------------------------------
  logic [LENW-1:0] decLen;
  logic [CYCW-1:0] decCyc;
  logic decVar;
  logic decCond;
  logic decKnown;

  // Per-opcode bytes and clocks
  always_comb begin
    decLen = LEN_1;
    decCyc = CYC_1;
    decVar = 1'b0;
    decCond = 1'b0;
    decKnown = 1'b1;
    if (aluRow && colRn) begin
      decCyc = CYC_1;
    end else if (aluRow && colRi) begin
      decCyc = CYC_2;
    end else if (aluRow && (colDir || colImm)) begin
      decLen = LEN_2;
      decCyc = CYC_2;
    end else if (logicRow && (col == COL_2)) begin
      decLen = LEN_2;
      decCyc = CYC_2;
    end else if (logicRow && (col == COL_3)) begin
      decLen = LEN_3;
      decCyc = CYC_3;
    end else if ((row == ROW_ORL || row == ROW_ANL || row == ROW_XRL || row == ROW_MOVI) && (col == COL_0)) begin
      decLen = LEN_2; // Conditional short branches
      decCyc = CYC_2;
      decCond = 1'b1;
    end else begin
      case (row)
        ROW_INC, ROW_DEC: begin
          if (colRi) begin
            decCyc = CYC_2;
          end else if (colDir) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else if (col == COL_3) begin
            decCyc = CYC_1;
          end else if (!(colRn || colImm || col == COL_0)) begin
            decKnown = 1'b0;
          end
        end
        ROW_ADD, ROW_ADDC: begin
          if (col == COL_3) begin
            decCyc = CYC_1;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_MOVI: begin
          if (colDir) begin
            decLen = LEN_3;
            decCyc = CYC_3;
          end else if (colRi) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else if (colRn || colImm) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_MOVD: begin
          if (colDir) begin
            decLen = LEN_3;
            decCyc = CYC_3;
          end else if (colImm) begin
            decCyc = CYC_8;
          end else if (col == COL_3) begin
            decCyc = CYC_3;
          end else if (colRi || colRn) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_SUBB: begin
          if (col == COL_0) begin
            decLen = LEN_3;
            decCyc = CYC_3;
          end else if (col == COL_3) begin
            decCyc = CYC_4;
            decVar = 1'b1;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_MOVR: begin
          if (colRi || colRn) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else if (colImm) begin
            decCyc = CYC_4;
          end else if (col == COL_3 || colDir) begin
            decCyc = CYC_1;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_XCH, ROW_POP: begin
          if (col == COL_0 || colDir || col == COL_2) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else if (colRi) begin
            decCyc = CYC_2;
          end else if (col == COL_3 || colImm || colRn) begin
            decCyc = CYC_1;
          end else begin
            decKnown = 1'b0;
          end
        end
        ROW_MOVA, ROW_STA: begin
          if (col == COL_0 || col == COL_2 || col == COL_3) begin
            decCyc = CYC_3;
          end else if (colRi || (row == ROW_STA && colImm)) begin
            decCyc = CYC_2;
          end else if (colDir) begin
            decLen = LEN_2;
            decCyc = CYC_2;
          end else if (!(colRn || colImm)) begin
            decKnown = 1'b0;
          end
        end
        default: begin
          decKnown = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Total clocks for this issue
  // ----------------------------------------
  logic [CYCW-1:0] varExtra;
  logic [CYCW-1:0] branchExtra;
  logic [CYCW-1:0] decTotal;

  // Code wait stretches the data pointer code read, taken branch adds a refill clock
  assign varExtra = decVar ? {{(CYCW-WAITW){1'b0}}, codeWait} : CNT_IDLE;
  assign branchExtra = (decCond && condTaken) ? CYC_TAKEN_EXTRA : CNT_IDLE;
  assign decTotal = decCyc + varExtra + branchExtra;

  // ----------------------------------------
  // Clock counter
  // ----------------------------------------
  logic accept;
  logic [CYCW-1:0] count;
  logic last;

  assign accept = opValid && opReady;

  cycle_counter #(
    .W(CYCW)
  ) u_counter (
    .clk(clk),
    .nrst(nrst),
    .load(accept),
    .loadValue(decTotal),
    .count(count),
    .last(last)
  );

  // ----------------------------------------
  // Next-state decode
  // ----------------------------------------
  logic next_busy;
  logic next_done;
  logic next_ready;

  // One issue busy for exactly its clock count
  assign next_busy = accept || ((state == ST_EXEC) && !last);
  assign next_done = accept ? (decTotal == CYC_1) : (busy && (count == CYC_2));
  assign next_ready = !next_busy || next_done;
  assign next_state = next_busy ? ST_EXEC : ST_IDLE;

  // Sequencer flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      execDone <= 1'b0;
      opReady <= 1'b1;
      pcStep <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_busy;
      execDone <= next_done;
      opReady <= next_ready;
      pcStep <= accept;
    end
  end

  // Latched attributes of the issued instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      instrLen <= LEN_1;
      execCycles <= CNT_IDLE;
      unknownOp <= 1'b0;
    end else if (accept) begin
      instrLen <= decLen;
      execCycles <= decTotal;
      unknownOp <= !decKnown;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_ALU_RN: assert property (accept && aluRow && colRn |=> execDone && instrLen == LEN_1)
    else $error("bank register ALU op not one byte one clock");
  AST_INDIRECT: assert property (accept && aluRow && colRi |=> !execDone ##1 execDone)
    else $error("indirect ALU op not two clocks");
  AST_MUL: assert property (accept && row == ROW_MOVR && colImm |=> !execDone [*3] ##1 execDone)
    else $error("multiply not four clocks");
  AST_DIV: assert property (accept && row == ROW_MOVD && colImm |=> !execDone [*7] ##1 execDone)
    else $error("divide not eight clocks");
  AST_DIR_DIR: assert property (accept && row == ROW_MOVD && colDir |=> instrLen == LEN_3 ##2 execDone)
    else $error("direct to direct move not three bytes three clocks");
  AST_MOVC_DPTR: assert property (accept && decVar |=> execCycles >= CYC_4 && execCycles <= CYC_7)
    else $error("data pointer code read outside four to seven clocks");
  AST_XDATA_RD: assert property (accept && row == ROW_MOVA
    && (col == COL_0 || col == COL_2 || col == COL_3) |=> !execDone [*2] ##1 execDone)
    else $error("external read not three clocks");
  AST_XDATA_WR: assert property (accept && row == ROW_STA
    && (col == COL_0 || col == COL_2 || col == COL_3) |=> instrLen == LEN_1 && !execDone ##1 !execDone ##1 execDone)
    else $error("external write not one byte three clocks");
  AST_NOT_TAKEN: assert property (accept && decCond && !condTaken |=> execCycles == {2'h0, instrLen})
    else $error("untaken branch clocks differ from bytes");
  AST_TAKEN: assert property (accept && decCond && condTaken
    |=> execCycles == {2'h0, instrLen} + CYC_TAKEN_EXTRA)
    else $error("taken branch not one clock longer");
  AST_PC_STEP: assert property (accept |=> pcStep && instrLen == $past(decLen))
    else $error("fetch unit not given byte length");
  AST_DONE_BUSY: assert property (execDone |-> busy && opReady)
    else $error("completion outside a busy instruction");
  AST_IMM_DIR: assert property (accept && aluRow && (colDir || colImm)
    |=> instrLen == LEN_2 && !execDone ##1 execDone)
    else $error("accumulator immediate or direct op not two bytes two clocks");
  AST_RMW_IMM: assert property (accept && logicRow && col == COL_3
    |=> instrLen == LEN_3 && !execDone ##1 !execDone ##1 execDone)
    else $error("immediate into direct byte not three bytes three clocks");
  AST_ACC_DIR: assert property (accept && logicRow && col == COL_2
    |=> instrLen == LEN_2 && !execDone ##1 execDone)
    else $error("accumulator into direct byte not two bytes two clocks");
  AST_ROT: assert property (accept && ((col == COL_3 && row <= ROW_ADDC) || (row == ROW_XCH && colImm))
    |=> execDone && instrLen == LEN_1)
    else $error("rotate or nibble swap not one byte one clock");
  AST_DPTR_LD: assert property (accept && row == ROW_SUBB && col == COL_0
    |=> instrLen == LEN_3 && !execDone ##1 !execDone ##1 execDone)
    else $error("data pointer load not three bytes three clocks");
  AST_MOVC_MIN: assert property (accept && decVar && codeWait == '0
    |=> instrLen == LEN_1 && !execDone [*3] ##1 execDone)
    else $error("data pointer code read without wait not four clocks");
  AST_MOVC_PC: assert property (accept && row == ROW_MOVD && col == COL_3
    |=> instrLen == LEN_1 && !execDone ##1 !execDone ##1 execDone)
    else $error("program counter code read not one byte three clocks");
  AST_STACK: assert property (accept && (row == ROW_XCH || row == ROW_POP) && col == COL_0
    |=> instrLen == LEN_2 && !execDone ##1 execDone)
    else $error("push or pop not two bytes two clocks");
  AST_XCHD: assert property (accept && row == ROW_POP && colRi
    |=> instrLen == LEN_1 && !execDone ##1 execDone)
    else $error("low nibble exchange not one byte two clocks");
  AST_IMM_IND: assert property (accept && row == ROW_MOVI && colRi
    |=> instrLen == LEN_2 && !execDone ##1 execDone)
    else $error("immediate into indirect memory not two bytes two clocks");
  AST_DIR_RN: assert property (accept && row == ROW_MOVR && colRn
    |=> instrLen == LEN_2 && !execDone ##1 execDone)
    else $error("direct byte into bank register not two bytes two clocks");

  COV_BACK_TO_BACK: cover property (execDone && accept ##1 busy);
  COV_DIVIDE: cover property (accept && row == ROW_MOVD && colImm);
  COV_TAKEN: cover property (accept && decCond && condTaken);
  COV_MOVC_MAX: cover property (accept && decVar && codeWait == 2'h3);
endmodule // instr_timing_decoder

/* File: rtl/instr_timing_pkg.sv */
// Constants for the instruction length and timing decoder
package instr_timing_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int OPW = 8;
  localparam int LENW = 2;
  localparam int CYCW = 4;
  localparam int WAITW = 2;

  // ----------------------------------------
  // Program byte lengths
  // ----------------------------------------
  localparam logic [LENW-1:0] LEN_1 = 2'h1;
  localparam logic [LENW-1:0] LEN_2 = 2'h2;
  localparam logic [LENW-1:0] LEN_3 = 2'h3;

  // ----------------------------------------
  // Execution clock counts
  // ----------------------------------------
  localparam logic [CYCW-1:0] CYC_1 = 4'h1;
  localparam logic [CYCW-1:0] CYC_2 = 4'h2;
  localparam logic [CYCW-1:0] CYC_3 = 4'h3;
  localparam logic [CYCW-1:0] CYC_4 = 4'h4;
  localparam logic [CYCW-1:0] CYC_7 = 4'h7;
  localparam logic [CYCW-1:0] CYC_8 = 4'h8;
  localparam logic [CYCW-1:0] CYC_TAKEN_EXTRA = 4'h1;
  localparam logic [CYCW-1:0] CNT_IDLE = 4'h0;

  // ----------------------------------------
  // Opcode rows (upper nibble)
  // ----------------------------------------
  localparam logic [3:0] ROW_INC = 4'h0;
  localparam logic [3:0] ROW_DEC = 4'h1;
  localparam logic [3:0] ROW_ADD = 4'h2;
  localparam logic [3:0] ROW_ADDC = 4'h3;
  localparam logic [3:0] ROW_ORL = 4'h4;
  localparam logic [3:0] ROW_ANL = 4'h5;
  localparam logic [3:0] ROW_XRL = 4'h6;
  localparam logic [3:0] ROW_MOVI = 4'h7;
  localparam logic [3:0] ROW_MOVD = 4'h8;
  localparam logic [3:0] ROW_SUBB = 4'h9;
  localparam logic [3:0] ROW_MOVR = 4'hA;
  localparam logic [3:0] ROW_XCH = 4'hC;
  localparam logic [3:0] ROW_POP = 4'hD;
  localparam logic [3:0] ROW_MOVA = 4'hE;
  localparam logic [3:0] ROW_STA = 4'hF;

  // ----------------------------------------
  // Operand columns (lower nibble)
  // ----------------------------------------
  localparam logic [3:0] COL_0 = 4'h0;
  localparam logic [3:0] COL_2 = 4'h2;
  localparam logic [3:0] COL_3 = 4'h3;
  localparam logic [3:0] COL_IMM = 4'h4;
  localparam logic [3:0] COL_DIR = 4'h5;
  localparam logic [2:0] COL_IND = 3'h3;
endpackage

/* File: test/cpu_instruction_timing_decoder_bench.sv */
// Self-checking bench for the instruction length and timing decoder
`timescale 1ns/1ps
module cpu_instruction_timing_decoder_bench;
  import instr_timing_pkg::*;
  typedef struct {logic [7:0] op; logic tk; logic [1:0] wt; logic [1:0] len; logic [3:0] cyc; logic unk;} ent_s;
  logic clk, nrst, go, opValid, condTaken, opReady, busy, execDone, pcStep, unknownOp, live;
  logic [OPW-1:0] opcode;
  logic [7:0] progEnd, pc, wp;
  logic [WAITW-1:0] codeWait;
  logic [LENW-1:0] instrLen;
  logic [CYCW-1:0] execCycles;
  ent_s expQ[$];
  ent_s cur;
  int err_total, n_checks, cyc, startCyc, doneCnt, nEnt;

  instr_timing_decoder instr_timing_decoder_inst (.clk(clk), .nrst(nrst), .opValid(opValid), .opcode(opcode),
    .condTaken(condTaken), .codeWait(codeWait), .opReady(opReady), .busy(busy), .execDone(execDone),
    .pcStep(pcStep), .instrLen(instrLen), .execCycles(execCycles), .unknownOp(unknownOp));
  fetch_model fetch_model_inst (.clk(clk), .nrst(nrst), .go(go), .progEnd(progEnd), .opReady(opReady),
    .pcStep(pcStep), .instrLen(instrLen), .opValid(opValid), .opcode(opcode), .condTaken(condTaken),
    .codeWait(codeWait), .pc(pc));

  // ----------------------------------------
  // Clock and cycle count
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Per-instruction monitor: length, count, busy span and ready level
  always @(negedge clk) begin
    if (nrst) begin
      if (pcStep === 1'b1) begin
        live = 1'b1;
        if (expQ.size() == 0) begin
          chk(8'h00, 8'hFF);
        end else begin
          cur = expQ.pop_front();
          startCyc = cyc;
          chk(8'(instrLen), 8'(cur.len));
          chk(8'(execCycles), 8'(cur.cyc));
          chk(8'(unknownOp), 8'(cur.unk));
        end
      end
      chk(8'(busy), 8'(live));
      chk(8'(opReady), 8'(!live || execDone === 1'b1));
      if (execDone === 1'b1) begin
        chk(8'(cyc - startCyc + 1), 8'(cur.cyc));
        doneCnt++;
        live = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Program building and running
  // ----------------------------------------
  task automatic put(input logic [7:0] op, input logic tk, input logic [1:0] wt, input logic [1:0] len,
                     input logic [3:0] cy, input logic unk);
    fetch_model_inst.mem[wp] = {wt, tk, op};
    for (int i = 1; i < 3; i++) fetch_model_inst.mem[wp + 8'(i)] = 11'h000;
    wp = wp + 8'(len);
    expQ.push_back('{op, tk, wt, len, cy, unk});
  endtask

  task automatic put_all(input logic [63:0] ops, input int n, input logic [1:0] len, input logic [3:0] cy);
    for (int i = 0; i < n; i++) put(ops[8*i +: 8], 1'b0, 2'h0, len, cy, 1'b0);
  endtask

  task automatic run_prog();
    int k;
    progEnd = wp;
    nEnt = expQ.size();
    doneCnt = 0;
    k = 0;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while ((expQ.size() != 0 || busy !== 1'b0) && k < 400) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    chk(8'(k >= 400), 8'h00);
    chk(pc, wp);
    chk(8'(doneCnt), 8'(nEnt));
    wp = 8'h00;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_alu();
    put_all(64'h6C4A599B3F28, 6, 2'h1, 4'h1);
    run_prog();
  endtask

  task automatic t_ind();
    put_all(64'hF6E7160726, 5, 2'h1, 4'h2);
    run_prog();
  endtask

  task automatic t_imm();
    put_all(64'h94352524, 4, 2'h2, 4'h2);
    put_all(64'h6252, 2, 2'h2, 4'h2);
    put_all(64'h634353, 3, 2'h3, 4'h3);
    run_prog();
  endtask

  task automatic t_muldiv();
    put(8'hA4, 1'b0, 2'h0, 2'h1, 4'h4, 1'b0);
    put(8'h84, 1'b0, 2'h0, 2'h1, 4'h8, 1'b0);
    put(8'h84, 1'b0, 2'h0, 2'h1, 4'h8, 1'b0);
    run_prog();
  endtask

  task automatic t_rot();
    put_all(64'hC413033323, 5, 2'h1, 4'h1);
    run_prog();
  endtask

  task automatic t_move();
    put(8'h85, 1'b0, 2'h0, 2'h3, 4'h3, 1'b0);
    put(8'h90, 1'b0, 2'h0, 2'h3, 4'h3, 1'b0);
    put(8'h83, 1'b0, 2'h0, 2'h1, 4'h3, 1'b0);
    for (int w = 0; w < 4; w++) put(8'h93, 1'b0, 2'(w), 2'h1, 4'(4 + w), 1'b0);
    run_prog();
  endtask

  task automatic t_ext();
    put_all(64'hF3F2F0E3E2E0, 6, 2'h1, 4'h3);
    run_prog();
  endtask

  task automatic t_stack();
    put_all(64'hD0C0, 2, 2'h2, 4'h2);
    put(8'hD6, 1'b0, 2'h0, 2'h1, 4'h2, 1'b0);
    put(8'h76, 1'b0, 2'h0, 2'h2, 4'h2, 1'b0);
    put(8'hA8, 1'b0, 2'h0, 2'h2, 4'h2, 1'b0);
    run_prog();
  endtask

  task automatic t_branch();
    for (int b = 0; b < 8; b++) put(8'h40 + 8'(16 * (b / 2)), 1'(b), 2'h0, 2'h2, 4'(2 + b % 2), 1'b0);
    put(8'h12, 1'b0, 2'h0, 2'h1, 4'h1, 1'b1);
    run_prog();
  endtask

  // Reset pulled in the middle of a divide, then released
  task automatic t_reset();
    put(8'h84, 1'b0, 2'h0, 2'h1, 4'h8, 1'b0);
    progEnd = wp;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    chk({opReady, busy, execDone, pcStep, unknownOp, 3'h0}, 8'h80);
    chk({2'h0, instrLen, execCycles}, 8'h10);
    live = 1'b0;
    expQ.delete();
    wp = 8'h00;
    nrst = 1'b1;
    @(negedge clk);
    chk({opReady, busy, execDone, pcStep, unknownOp, 3'h0}, 8'h80);
  endtask

  // Watchdog against a hung handshake
  initial begin
    #20000;
    err_total++;
    summarize();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    go = 1'b0;
    progEnd = 8'h00;
    wp = 8'h00;
    live = 1'b0;
    cyc = 0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({opReady, busy, execDone, pcStep, unknownOp, 3'h0}, 8'h80);
    chk({2'h0, instrLen, execCycles}, 8'h10);
    nrst = 1'b1;
    t_alu();
    t_ind();
    t_imm();
    t_muldiv();
    t_reset();
    t_rot();
    t_move();
    t_ext();
    t_stack();
    t_branch();
    summarize();
  end
endmodule // cpu_instruction_timing_decoder_bench

/* File: test/fetch_model.sv */
// Fetch path model: offers opcodes from a program store and steps by the decoded length
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [7:0] progEnd,
  input wire logic opReady,
  input wire logic pcStep,
  input wire logic [instr_timing_pkg::LENW-1:0] instrLen,
  output logic opValid,
  output logic [instr_timing_pkg::OPW-1:0] opcode,
  output logic condTaken,
  output logic [instr_timing_pkg::WAITW-1:0] codeWait,
  output logic [7:0] pc
);
  import instr_timing_pkg::*;
  logic [10:0] mem [0:255];
  logic acc;

  // Remember whether the last rising edge took the offer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc <= 1'b0;
    end else begin
      acc <= opValid & opReady;
    end
  end

  // Offer held until taken; released lines show the inverse, not stale data
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      pc = 8'h00;
      opValid = 1'b0;
      {codeWait, condTaken, opcode} = 11'h000;
    end else if (go) begin
      pc = 8'h00;
      opValid = 1'b1;
      {codeWait, condTaken, opcode} = mem[pc];
    end else if (pcStep) begin
      pc = pc + 8'(instrLen); // Skip operand bytes
      opValid = (pc < progEnd);
      {codeWait, condTaken, opcode} = opValid ? mem[pc] : ~{codeWait, condTaken, opcode};
    end else if (acc) begin
      opValid = 1'b0;
      {codeWait, condTaken, opcode} = ~{codeWait, condTaken, opcode};
    end
  end
endmodule // fetch_model
